/* src/utopia_tx_pkg.sv */
package utopia_tx_pkg;
   localparam int NUM_CH = 4;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 5;
   // 53 octets plus the user-defined octet pad to 27 words on a 16-bit bus.
   localparam int CELL_OCTETS = 53;
   localparam int CELL_WORDS = (CELL_OCTETS + 1) / 2;
   localparam logic [ADDR_W-1:0] NULL_ADDR = 5'h1f;
   localparam logic [ADDR_W-1:0] BASE_ADDR_RST = 5'h00;
   // Host register map, byte offsets on the host's command port.
   localparam int REG_AW = 4;
   localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [REG_AW-1:0] REG_DATA = 4'h4;
   localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
   localparam int CTRL_ODD_BIT = 5;
   localparam int CTRL_INJ_BIT = 6;
   localparam int DATA_SOC_BIT = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TCA_BIT = 1;
   localparam logic [ADDR_W-1:0] TARGET_RST = 5'h00;
   // Link clock made by the host from its own clock.
   localparam int CLK_PERIOD_NS = 5;
   localparam int TFCLK_PERIOD_NS = 80;
   localparam int TFCLK_HALF = TFCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

/* src/utopia_tx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface utopia_tx_if;
   logic tfclk;
   logic [utopia_tx_pkg::WORD_W-1:0] tdat;
   logic tprty;
   logic tsoc;
   logic tenb_b;
   logic [utopia_tx_pkg::ADDR_W-1:0] tadr;
   logic tca;
   modport phy (input tfclk, input tdat, input tprty, input tsoc, input tenb_b, input tadr,
      output tca);
   modport master (output tfclk, output tdat, output tprty, output tsoc, output tenb_b,
      output tadr, input tca);
endinterface
`default_nettype wire

/* src/utopia_tx_phy.sv */
`timescale 1ns/1ps
`default_nettype none
module utopia_tx_phy #(
   parameter logic [4:0] BASE_ADDR = utopia_tx_pkg::BASE_ADDR_RST
) (
   utopia_tx_if.phy link,
   input wire logic rst_b,
   input wire logic cell_mode,
   input wire logic [utopia_tx_pkg::NUM_CH-1:0] parity_type_select,
   input wire logic [1:0] irq_mask,
   input wire logic err_clear,
   output logic [utopia_tx_pkg::NUM_CH-1:0] parity_err,
   output logic [utopia_tx_pkg::NUM_CH-1:0] soc_err,
   output logic irq,
   input wire logic out_ready,
   output logic out_valid,
   output logic [1:0] out_ch,
   output logic [utopia_tx_pkg::WORD_W-1:0] out_data,
   output logic out_soc,
   output logic out_idle
);
   localparam int NCH = utopia_tx_pkg::NUM_CH;
   localparam int CW = utopia_tx_pkg::CELL_WORDS;
   localparam int WW = utopia_tx_pkg::WORD_W;
   localparam logic [4:0] LAST_IDX = 5'(CW - 1);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Write side: selection, buffers, error flags.

   logic [1:0] sel_ch;
   logic sel_ok;
   logic [1:0] out_ch_sel;
   logic [4:0] wcnt [NCH];
   logic [NCH-1:0] full;
   logic [WW:0] mem [NCH][CW];
   logic tca_q;

   logic [1:0] next_sel_ch;
   logic next_sel_ok;
   logic [4:0] next_wcnt [NCH];
   logic [NCH-1:0] next_full;
   logic [NCH-1:0] next_parity_err;
   logic [NCH-1:0] next_soc_err;
   logic next_tca;
   logic [4:0] off;
   logic hit;
   logic valid_wr;
   logic accept;
   logic [4:0] widx;
   logic release_cell;

   always_comb begin
      off = link.tadr - BASE_ADDR;
      hit = (link.tadr != utopia_tx_pkg::NULL_ADDR) && (off < 5'(NCH));
      next_sel_ch = sel_ch;
      next_sel_ok = sel_ok;
      if (link.tenb_b) begin
         next_sel_ch = off[1:0];
         next_sel_ok = hit;
      end
      valid_wr = !link.tenb_b && sel_ok;
      widx = wcnt[sel_ch];
      // In cell mode a start marker realigns the count, otherwise the count alone frames cells.
      if (cell_mode && link.tsoc) begin
         widx = 5'h00;
      end
      // A full buffer refuses writes until its cell has left; the word is dropped.
      accept = valid_wr && !full[sel_ch];
      next_wcnt = wcnt;
      next_full = full;
      if (release_cell) begin
         next_full[out_ch_sel] = 1'b0;
      end
      if (accept) begin
         if (widx == LAST_IDX) begin
            next_wcnt[sel_ch] = 5'h00;
            next_full[sel_ch] = 1'b1;
         end else begin
            next_wcnt[sel_ch] = widx + 5'h01;
         end
      end
      next_parity_err = err_clear ? '0 : parity_err;
      next_soc_err = err_clear ? '0 : soc_err;
      // Set wins over a clear in the same cycle.
      if (valid_wr && (link.tprty != (^link.tdat ^ parity_type_select[sel_ch]))) begin
         next_parity_err[sel_ch] = 1'b1;
      end
      if (valid_wr && cell_mode && link.tsoc && (wcnt[sel_ch] != 5'h00)) begin
         next_soc_err[sel_ch] = 1'b1;
      end
      next_tca = hit && !full[off[1:0]];
   end

   always_ff @(posedge link.tfclk or negedge rst_b) begin
      if (!rst_b) begin
         sel_ch <= 2'h0;
         sel_ok <= 1'b0;
         full <= '0;
         parity_err <= '0;
         soc_err <= '0;
         tca_q <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            wcnt[i] <= 5'h00;
         end
      end else begin
         sel_ch <= next_sel_ch;
         sel_ok <= next_sel_ok;
         wcnt <= next_wcnt;
         full <= next_full;
         parity_err <= next_parity_err;
         soc_err <= next_soc_err;
         tca_q <= next_tca;
      end
   end

   // Buffer storage carries no reset; a word is only read once its cell is full.
   always_ff @(posedge link.tfclk) begin
      if (accept) begin
         mem[sel_ch][widx] <= {link.tsoc, link.tdat};
      end
   end

   assign link.tca = tca_q;
   assign irq = (|parity_err && irq_mask[0]) || (|soc_err && irq_mask[1]);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Transmit stream: one cell slot per channel in turn, idle when that channel has no complete cell.

   logic [4:0] rd_idx;
   logic rd_idle;
   logic [1:0] next_out_ch_sel;
   logic [4:0] next_rd_idx;
   logic next_rd_idle;
   logic cur_idle;
   logic adv;
   logic next_out_valid;
   logic [1:0] next_out_ch;
   logic [WW-1:0] next_out_data;
   logic next_out_soc;
   logic next_out_idle;

   always_comb begin
      adv = !out_valid || out_ready;
      cur_idle = (rd_idx == 5'h00) ? !full[out_ch_sel] : rd_idle;
      next_out_ch_sel = out_ch_sel;
      next_rd_idx = rd_idx;
      next_rd_idle = rd_idle;
      release_cell = 1'b0;
      next_out_valid = out_valid;
      next_out_ch = out_ch;
      next_out_data = out_data;
      next_out_soc = out_soc;
      next_out_idle = out_idle;
      if (adv) begin
         next_out_valid = 1'b1;
         next_out_ch = out_ch_sel;
         next_out_idle = cur_idle;
         next_out_data = cur_idle ? '0 : mem[out_ch_sel][rd_idx][WW-1:0];
         if (cell_mode || cur_idle) begin
            next_out_soc = (rd_idx == 5'h00);
         end else begin
            next_out_soc = mem[out_ch_sel][rd_idx][WW];
         end
         next_rd_idle = cur_idle;
         if (rd_idx == LAST_IDX) begin
            next_rd_idx = 5'h00;
            next_out_ch_sel = out_ch_sel + 2'h1;
            release_cell = !cur_idle;
         end else begin
            next_rd_idx = rd_idx + 5'h01;
         end
      end
   end

   always_ff @(posedge link.tfclk or negedge rst_b) begin
      if (!rst_b) begin
         out_ch_sel <= 2'h0;
         rd_idx <= 5'h00;
         rd_idle <= 1'b1;
         out_valid <= 1'b0;
         out_ch <= 2'h0;
         out_data <= '0;
         out_soc <= 1'b0;
         out_idle <= 1'b1;
      end else begin
         out_ch_sel <= next_out_ch_sel;
         rd_idx <= next_rd_idx;
         rd_idle <= next_rd_idle;
         out_valid <= next_out_valid;
         out_ch <= next_out_ch;
         out_data <= next_out_data;
         out_soc <= next_out_soc;
         out_idle <= next_out_idle;
      end
   end
endmodule // utopia_tx_phy
`default_nettype wire

/* src/utopia_tx_master.sv */
`timescale 1ns/1ps
`default_nettype none
module utopia_tx_master #(
   parameter int HALF_PERIOD = utopia_tx_pkg::TFCLK_HALF
) (
   utopia_tx_if.master link,
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [utopia_tx_pkg::REG_AW-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   localparam int WW = utopia_tx_pkg::WORD_W;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Link clock divider and word driver.

   logic [7:0] div;
   logic tfclk_q;
   logic [4:0] target;
   logic odd;
   logic inject;
   logic pend;
   logic [WW:0] pend_word;
   logic sel_done;
   logic [WW-1:0] tdat_q;
   logic tprty_q;
   logic tsoc_q;
   logic tenb_b_q;
   logic [4:0] tadr_q;
   logic tca_s1;
   logic tca_s2;

   logic [7:0] next_div;
   logic next_tfclk;
   logic [4:0] next_target;
   logic next_odd;
   logic next_inject;
   logic next_pend;
   logic [WW:0] next_pend_word;
   logic next_sel_done;
   logic [WW-1:0] next_tdat;
   logic next_tprty;
   logic next_tsoc;
   logic next_tenb_b;
   logic [4:0] next_tadr;
   logic [31:0] next_rdata;
   logic tick;
   logic fall;

   always_comb begin
      tick = (div == 8'(HALF_PERIOD - 1));
      next_div = tick ? 8'h00 : div + 8'h01;
      next_tfclk = tick ? !tfclk_q : tfclk_q;
      // Outputs change at the falling link edge, half a period before the device samples.
      fall = tick && tfclk_q;
      next_target = target;
      next_odd = odd;
      next_inject = inject;
      next_pend = pend;
      next_pend_word = pend_word;
      next_sel_done = sel_done;
      next_tdat = tdat_q;
      next_tprty = tprty_q;
      next_tsoc = tsoc_q;
      next_tenb_b = tenb_b_q;
      next_tadr = tadr_q;
      if (fall) begin
         next_tadr = target;
         if (pend && sel_done) begin
            next_tenb_b = 1'b0;
            next_tdat = pend_word[WW-1:0];
            next_tsoc = pend_word[WW];
            next_tprty = ^pend_word[WW-1:0] ^ odd ^ inject;
            next_pend = 1'b0;
         end else begin
            // An idle cycle both polls and selects the target port.
            next_tenb_b = 1'b1;
            next_tdat = '0;
            next_tsoc = 1'b0;
            next_tprty = odd;
            next_sel_done = 1'b1;
         end
      end
      if (wr && addr == utopia_tx_pkg::REG_CTRL) begin
         next_target = wdata[4:0];
         next_odd = wdata[utopia_tx_pkg::CTRL_ODD_BIT];
         next_inject = wdata[utopia_tx_pkg::CTRL_INJ_BIT];
         next_sel_done = 1'b0;
      end
      // A data write while a word is still pending is ignored.
      if (wr && addr == utopia_tx_pkg::REG_DATA && !pend) begin
         next_pend = 1'b1;
         next_pend_word = wdata[utopia_tx_pkg::DATA_SOC_BIT:0];
      end
      next_rdata = 32'h0000_0000;
      if (rd && addr == utopia_tx_pkg::REG_CTRL) begin
         next_rdata = {25'h0, inject, odd, target};
      end else if (rd && addr == utopia_tx_pkg::REG_STATUS) begin
         next_rdata = {30'h0, tca_s2, pend};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div <= 8'h00;
         tfclk_q <= 1'b0;
         target <= utopia_tx_pkg::TARGET_RST;
         odd <= 1'b0;
         inject <= 1'b0;
         pend <= 1'b0;
         pend_word <= '0;
         sel_done <= 1'b0;
         tdat_q <= '0;
         tprty_q <= 1'b0;
         tsoc_q <= 1'b0;
         tenb_b_q <= 1'b1;
         tadr_q <= utopia_tx_pkg::NULL_ADDR;
         tca_s1 <= 1'b0;
         tca_s2 <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         div <= next_div;
         tfclk_q <= next_tfclk;
         target <= next_target;
         odd <= next_odd;
         inject <= next_inject;
         pend <= next_pend;
         pend_word <= next_pend_word;
         sel_done <= next_sel_done;
         tdat_q <= next_tdat;
         tprty_q <= next_tprty;
         tsoc_q <= next_tsoc;
         tenb_b_q <= next_tenb_b;
         tadr_q <= next_tadr;
         tca_s1 <= link.tca;
         tca_s2 <= tca_s1;
         rdata <= next_rdata;
      end
   end

   assign link.tfclk = tfclk_q;
   assign link.tdat = tdat_q;
   assign link.tprty = tprty_q;
   assign link.tsoc = tsoc_q;
   assign link.tenb_b = tenb_b_q;
   assign link.tadr = tadr_q;
endmodule // utopia_tx_master
`default_nettype wire

/* dv/utopia_tx_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module utopia_tx_asserts #(
   parameter int HALF_PERIOD = utopia_tx_pkg::TFCLK_HALF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tfclk,
   input wire logic tsoc,
   input wire logic tenb_b,
   input wire logic [utopia_tx_pkg::ADDR_W-1:0] tadr,
   input wire logic tca
);
   logic tq;
   logic seen;
   int cnt;
   logic [5:0] wc;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tq <= 1'b0;
         seen <= 1'b0;
         // This count lags the link clock by one edge, so start one below zero to match the
         // divider's first phase after reset.
         cnt <= -1;
      end else begin
         tq <= tfclk;
         seen <= seen | (tfclk != tq);
         cnt <= (tfclk != tq) ? 0 : cnt + 1;
      end
   end
   // Words in the current cell, restarting at a start marker or after 27 words; null-port writes are ignored by the far end.
   always_ff @(posedge tfclk or negedge rst_b) begin
      if (!rst_b) begin
         wc <= 6'h00;
      end else if (!tenb_b && tadr != utopia_tx_pkg::NULL_ADDR) begin
         wc <= (tsoc || wc == 6'h1b) ? 6'h01 : wc + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_half_max: assert property (@(posedge clk) disable iff (!rst_b) cnt < HALF_PERIOD)
      else $error("link clock phase too long");
   a_half_exact: assert property (@(posedge clk) disable iff (!rst_b)
      (seen && tfclk != tq) |-> cnt == HALF_PERIOD - 1) else $error("link clock phase wrong");
   a_select_first: assert property (@(posedge tfclk) disable iff (!rst_b)
      $fell(tenb_b) |-> $stable(tadr)) else $error("write without select cycle");
   a_no_retarget: assert property (@(posedge tfclk) disable iff (!rst_b)
      $changed(tadr) |-> tenb_b) else $error("address moved during write");
   a_burst_hold: assert property (@(posedge tfclk) disable iff (!rst_b)
      !tenb_b [*2] |-> $stable(tadr)) else $error("selection lost in burst");
   a_null_no_tca: assert property (@(posedge tfclk) disable iff (!rst_b)
      tadr == utopia_tx_pkg::NULL_ADDR |=> !tca) else $error("null port answered");
   a_unmapped_no_tca: assert property (@(posedge tfclk) disable iff (!rst_b)
      (tadr > 5'h03 && tadr != utopia_tx_pkg::NULL_ADDR) |=> !tca)
      else $error("foreign port answered");
   a_cell_full: assert property (@(posedge tfclk) disable iff (!rst_b)
      (!tenb_b && !tsoc && wc == 6'h1a && tadr <= 5'h03) ##1 $stable(tadr) |=> !tca)
      else $error("full cell still available");
   c_select: cover property (@(posedge tfclk) disable iff (!rst_b) $fell(tenb_b));
   c_full: cover property (@(posedge tfclk) disable iff (!rst_b) !tenb_b && wc == 6'h1a);
   c_null: cover property (@(posedge tfclk) disable iff (!rst_b)
      tenb_b && tadr == utopia_tx_pkg::NULL_ADDR);
endmodule // utopia_tx_asserts
`default_nettype wire

/* dv/utopia_pos_tx_write_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module utopia_pos_tx_write_port_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [3:0] parity_type_select = 4'h2;
   logic [1:0] irq_mask = 2'h0;
   logic err_clear = 1'b0;
   logic out_ready = 1'b0;
   logic cell_mode = 1'b1;
   logic [3:0] parity_err;
   logic [3:0] soc_err;
   logic irq;
   logic out_valid;
   logic out_soc;
   logic out_idle;
   logic [1:0] out_ch;
   logic [15:0] out_data;
   logic [16:0] q[4][$];
   logic [31:0] s;
   int num_errors = 0;
   int tests_run = 0;
   utopia_tx_if link_if();
   utopia_tx_master utopia_tx_master_i(.link(link_if), .clk(clk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   utopia_tx_phy utopia_tx_phy_i(.link(link_if), .rst_b(rst_b), .cell_mode(cell_mode),
      .parity_type_select(parity_type_select), .irq_mask(irq_mask), .err_clear(err_clear),
      .parity_err(parity_err), .soc_err(soc_err), .irq(irq), .out_ready(out_ready),
      .out_valid(out_valid), .out_ch(out_ch), .out_data(out_data), .out_soc(out_soc),
      .out_idle(out_idle));
   utopia_tx_asserts utopia_tx_asserts_i(.clk(clk), .rst_b(rst_b), .tfclk(link_if.tfclk),
      .tsoc(link_if.tsoc), .tenb_b(link_if.tenb_b), .tadr(link_if.tadr), .tca(link_if.tca));
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge link_if.tfclk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1 && out_idle === 1'b0) begin
         q[out_ch].push_back({out_soc, out_data});
      end
      if (out_valid === 1'b1 && out_ready === 1'b1 && out_idle === 1'b1) begin
         chk("idle payload", 32'h0, {16'h0, out_data});
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_stat(input int b, input logic v);
      int n;
      n = 0;
      reg_rd(utopia_tx_pkg::REG_STATUS, s);
      while (s[b] !== v) begin
         n++;
         if (n > 400) begin
            chk("status bit", {31'h0, v}, {31'h0, s[b]});
            report_and_stop();
         end
         reg_rd(utopia_tx_pkg::REG_STATUS, s);
      end
   endtask
   // The data word carries its port and index, so misrouted or reordered words show.
   task automatic words(input logic [4:0] t, input int first, input int last, input logic m);
      for (int i = first; i <= last; i++) begin
         wait_stat(utopia_tx_pkg::STAT_BUSY_BIT, 1'b0);
         reg_wr(utopia_tx_pkg::REG_DATA, {15'h0, m && i == first, 3'h0, t, 8'(i)});
      end
      wait_stat(utopia_tx_pkg::STAT_BUSY_BIT, 1'b0);
   endtask
   // The mask sm gives, word by word, where the stream must show a start marker.
   task automatic drain(input logic [1:0] c, input int off, input logic [26:0] sm);
      int n;
      n = 0;
      while (q[c].size() < utopia_tx_pkg::CELL_WORDS) begin
         @(posedge link_if.tfclk);
         n++;
         if (n > 600) begin
            chk("cell words", 32'd27, 32'(q[c].size()));
            report_and_stop();
         end
      end
      for (int i = 0; i < utopia_tx_pkg::CELL_WORDS; i++) begin
         chk("cell word", {15'h0, sm[i], 6'h0, c, 8'(off + i)}, {15'h0, q[c][i]});
      end
      q[c].delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_release();
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h0);
      words(5'h00, 0, 25, 1'b1);
      repeat (120) @(posedge link_if.tfclk);
      chk("early words", 32'h0, 32'(q[0].size()));
      words(5'h00, 26, 26, 1'b0);
      drain(2'h0, 0, 27'h1);
      // The stream side lives on the link clock, so its inputs move on that clock only.
      @(posedge link_if.tfclk);
      out_ready <= 1'b0;
      words(5'h00, 0, 26, 1'b0);
      wait_stat(utopia_tx_pkg::STAT_TCA_BIT, 1'b0);
      @(posedge link_if.tfclk);
      out_ready <= 1'b1;
      drain(2'h0, 0, 27'h1);
      wait_stat(utopia_tx_pkg::STAT_TCA_BIT, 1'b1);
   endtask
   task automatic t_parity();
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h1);
      words(5'h01, 0, 26, 1'b1);
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h2);
      words(5'h02, 0, 26, 1'b1);
      drain(2'h1, 0, 27'h1);
      drain(2'h2, 0, 27'h1);
      chk("parity flags", 32'h2, {28'h0, parity_err});
      chk("masked irq", 32'h0, {31'h0, irq});
      irq_mask <= 2'h1;
      @(posedge clk);
      #1 chk("parity irq", 32'h1, {31'h0, irq});
      @(posedge link_if.tfclk) err_clear <= 1'b1;
      @(posedge link_if.tfclk) err_clear <= 1'b0;
      @(posedge link_if.tfclk) irq_mask <= 2'h2;
      #1 chk("cleared flags", 32'h0, {28'h0, parity_err});
   endtask
   task automatic t_soc();
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h3);
      words(5'h03, 0, 4, 1'b1);
      words(5'h03, 5, 31, 1'b1);
      chk("marker flags", 32'h8, {28'h0, soc_err});
      chk("marker irq", 32'h1, {31'h0, irq});
      drain(2'h3, 5, 27'h1);
   endtask
   // Two packets share one chunk; odd plus injected parity cancel, injection alone fails.
   task automatic t_packet();
      @(posedge link_if.tfclk);
      cell_mode <= 1'b0;
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h60);
      words(5'h00, 0, 9, 1'b1);
      chk("odd parity", 32'h0, {28'h0, parity_err});
      reg_wr(utopia_tx_pkg::REG_CTRL, 32'h40);
      reg_rd(utopia_tx_pkg::REG_CTRL, s);
      chk("control readback", 32'h40, s);
      words(5'h00, 10, 26, 1'b1);
      chk("injected parity", 32'h1, {28'h0, parity_err});
      chk("packet marker flags", 32'h8, {28'h0, soc_err});
      drain(2'h0, 0, 27'h401);
   endtask
   task automatic t_null();
      for (int k = 0; k < 2; k++) begin
         reg_wr(utopia_tx_pkg::REG_CTRL, k == 0 ? 32'h1f : 32'h04);
         words(k == 0 ? 5'h1f : 5'h04, 0, 0, 1'b1);
         wait_stat(utopia_tx_pkg::STAT_TCA_BIT, 1'b0);
      end
      repeat (120) @(posedge link_if.tfclk);
      for (int c = 0; c < 4; c++) chk("stray words", 32'h0, 32'(q[c].size()));
      reg_rd(4'hc, s);
      chk("unmapped read", 32'h0, s);
   endtask
   initial begin
      // Reset falls by a nonblocking update at time zero, so every asynchronous reset sees an edge.
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      chk("reset valid", 32'h0, {31'h0, out_valid});
      rst_b <= 1'b1;
      out_ready <= 1'b1;
      t_release();
      t_parity();
      t_soc();
      t_packet();
      t_null();
      report_and_stop();
   end
endmodule // utopia_pos_tx_write_port_tb
`default_nettype wire
